// ==== hdl/lwd_pkg.sv ====
package lwd_pkg;
  // ==========================================================
  // timing
  localparam int LWD_POR_CLR_CYCLES = 4096;
  localparam int LWD_CNT_W = 13;
  // ==========================================================
  // vector and config layout, power-on states
  localparam logic [15:0] LWD_RESET_VECTOR = 16'hFFFE;
  localparam int LWD_CFG_DIS_BIT = 0;
  localparam int LWD_CFG_RATE_BIT = 1;
  localparam logic [7:0] LWD_CFG_RESET = 8'h00;
  typedef enum logic [1:0] {LWD_POR_WAIT, LWD_POR_DONE} lwd_por_t;
endpackage : lwd_pkg

// ==== hdl/lwd_cfg_if.sv ====
`timescale 1ns/1ps
interface lwd_cfg_if;
  logic disableWd;
  logic rateSel;
  modport src (output disableWd, output rateSel);
  modport dst (input disableWd, input rateSel);
endinterface : lwd_cfg_if

// ==== hdl/lwd_cfg_follow.sv ====
`timescale 1ns/1ps
module lwd_cfg_follow (
  // config byte
  input wire logic [7:0] cfgReg,
  // decoded signals
  lwd_cfg_if.src cfg
);
  import lwd_pkg::*;
  assign cfg.disableWd = cfgReg[LWD_CFG_DIS_BIT];
  assign cfg.rateSel = cfgReg[LWD_CFG_RATE_BIT];
endmodule : lwd_cfg_follow

// ==== hdl/lwd_clear_ctrl.sv ====
`timescale 1ns/1ps
module lwd_clear_ctrl #(
  // cycles from power-on release to the prescaler clear
  parameter int PorCycles = lwd_pkg::LWD_POR_CLR_CYCLES
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic rst,
  // internal reset and vector bus
  input wire logic intReset,
  input wire logic [15:0] dataBus,
  input wire logic vecFetch,
  // option configuration byte
  input wire logic [7:0] cfgReg,
  // watchdog counter raw timeout
  input wire logic wdTimeout,
  // outputs to watchdog
  output logic prescClr,
  output logic cntClr,
  output logic unitCntClr,
  output logic watchdogDisable,
  output logic watchdogRateSelect,
  output logic wdResetReq
);
  import lwd_pkg::*;
  // limitation: PorCycles + 1 must fit in LWD_CNT_W bits
  localparam logic [LWD_CNT_W-1:0] PorLast = LWD_CNT_W'(PorCycles - 1);
  localparam logic [LWD_CNT_W-1:0] PorEdge = LWD_CNT_W'(PorCycles);
  localparam logic [LWD_CNT_W-1:0] SinceTop = LWD_CNT_W'(PorCycles + 1);

  lwd_cfg_if cfgBus ();
  lwd_por_t porState_r;
  logic [LWD_CNT_W-1:0] porCnt_r;
  logic porFire;
  logic vecHit;
  logic timeoutLive;
  // edge count since release, kept apart from porCnt_r so the checks do not trust it
  logic [LWD_CNT_W-1:0] chkSince_r;

  // ==========================================================
  // configuration follow
  lwd_cfg_follow uCfg (
    .cfgReg(cfgReg),
    .cfg(cfgBus)
  );
  // plain wires, so the outputs track the byte even while rst is held
  assign watchdogDisable = cfgBus.disableWd;
  assign watchdogRateSelect = cfgBus.rateSel;

  a_disable_follow: assert property (
    @(posedge mclk) disable iff (rst)
    watchdogDisable == cfgReg[LWD_CFG_DIS_BIT])
    else $error("disable output not following config");

  a_rate_follow: assert property (
    @(posedge mclk) disable iff (rst)
    watchdogRateSelect == cfgReg[LWD_CFG_RATE_BIT])
    else $error("rate select output not following config");

  // ==========================================================
  // power-on delay
  always_ff @(posedge mclk) begin
    if (rst) begin
      porState_r <= LWD_POR_WAIT;
      porCnt_r <= '0;
    end else begin
      unique case (porState_r)
        LWD_POR_WAIT: begin
          if (porCnt_r == PorLast) begin
            porState_r <= LWD_POR_DONE;
          end else begin
            porCnt_r <= porCnt_r + 1'b1;
          end
        end
        // done is terminal until rst, so nothing later can re-arm the wait
        LWD_POR_DONE: begin
          porState_r <= LWD_POR_DONE;
        end
        default: porState_r <= LWD_POR_WAIT;
      endcase
    end
  end

  // the wait ends on the edge that sees the terminal count, once per reset
  assign porFire = (porState_r == LWD_POR_WAIT) && (porCnt_r == PorLast);

  // saturates one past the power-on edge so a late pulse is still caught
  always_ff @(posedge mclk) begin
    if (rst) begin
      chkSince_r <= '0;
    end else if (chkSince_r != SinceTop) begin
      chkSince_r <= chkSince_r + 1'b1;
    end
  end

  a_por_clear_time: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(porState_r == LWD_POR_DONE) |-> prescClr)
    else $error("prescaler not cleared at end of power-on wait");

  // both directions pin the end of the wait to exactly PorCycles edges after release
  a_por_wait_len: assert property (
    @(posedge mclk) disable iff (rst)
    porFire |-> (chkSince_r == PorLast))
    else $error("power-on wait ended early or late");

  a_por_due: assert property (
    @(posedge mclk) disable iff (rst)
    (chkSince_r == PorLast) |-> porFire)
    else $error("power-on wait did not end on time");

  a_por_once: assert property (
    @(posedge mclk) disable iff (rst)
    (porState_r == LWD_POR_DONE) |=> (porState_r == LWD_POR_DONE))
    else $error("power-on wait restarted without reset");

  a_por_frozen: assert property (
    @(posedge mclk) disable iff (rst)
    (porState_r == LWD_POR_DONE) |-> $stable(porCnt_r))
    else $error("power-on counter moved after the wait");

  c_por_done: cover property (@(posedge mclk) disable iff (rst)
    $rose(porState_r == LWD_POR_DONE));

  // ==========================================================
  // prescaler clear
  assign vecHit = vecFetch && (dataBus == LWD_RESET_VECTOR);
  // a vector hit on the power-on edge merges into one pulse; both clear the same prescaler
  always_ff @(posedge mclk) begin
    if (rst) begin
      prescClr <= 1'b0;
    end else begin
      prescClr <= porFire || vecHit;
    end
  end

  a_vector_clear: assert property (
    @(posedge mclk) disable iff (rst)
    (vecFetch && dataBus == LWD_RESET_VECTOR) |=> prescClr)
    else $error("vector fetch did not clear prescaler");

  a_vector_miss: assert property (
    @(posedge mclk) disable iff (rst)
    (vecFetch && (dataBus != LWD_RESET_VECTOR) && !porFire) |=> !prescClr)
    else $error("prescaler cleared by another address");

  a_presc_idle: assert property (
    @(posedge mclk) disable iff (rst)
    (!vecFetch && !porFire) |=> !prescClr)
    else $error("prescaler cleared with no cause");

  // the reverse view: every pulse traces back to one of its two causes
  a_presc_cause: assert property (
    @(posedge mclk) disable iff (rst)
    prescClr |-> ($past(vecHit) || (chkSince_r == PorEdge)))
    else $error("prescaler clear with neither fetch nor power-on edge");

  c_vec_hit: cover property (@(posedge mclk) disable iff (rst) vecHit);

  // ==========================================================
  // counter clears
  // the internal reset is registered into both on the same edge, so they can never part
  always_ff @(posedge mclk) begin
    if (rst) begin
      cntClr <= 1'b0;
      unitCntClr <= 1'b0;
    end else begin
      cntClr <= intReset;
      unitCntClr <= intReset;
    end
  end

  a_int_reset_clr: assert property (
    @(posedge mclk) disable iff (rst)
    intReset |=> (cntClr && unitCntClr))
    else $error("internal reset did not clear counters");

  // a stuck clear would hold the counter and hide every timeout
  a_clr_quiet: assert property (
    @(posedge mclk) disable iff (rst)
    !intReset |=> (!cntClr && !unitCntClr))
    else $error("counter clear without internal reset");

  c_int_reset: cover property (@(posedge mclk) disable iff (rst)
    intReset ##1 (intReset && cntClr));

  // ==========================================================
  // watchdog reset request
  // disable is sampled with the timeout, so a disable that lands in the same cycle wins
  assign timeoutLive = wdTimeout && !cfgBus.disableWd;
  always_ff @(posedge mclk) begin
    if (rst) begin
      wdResetReq <= 1'b0;
    end else begin
      wdResetReq <= timeoutLive;
    end
  end

  a_disable_blocks: assert property (
    @(posedge mclk) disable iff (rst)
    $past(cfgReg[LWD_CFG_DIS_BIT]) |-> !wdResetReq)
    else $error("watchdog reset while disabled");

  a_timeout_passes: assert property (
    @(posedge mclk) disable iff (rst)
    (wdTimeout && !watchdogDisable) |=> wdResetReq)
    else $error("enabled timeout raised no reset request");

  a_req_quiet: assert property (
    @(posedge mclk) disable iff (rst)
    !wdTimeout |=> !wdResetReq)
    else $error("reset request with no timeout");

  c_wd_reset: cover property (@(posedge mclk) disable iff (rst) wdResetReq);
  c_masked_timeout: cover property (@(posedge mclk) disable iff (rst)
    (wdTimeout && watchdogDisable) ##1 !wdResetReq);
endmodule : lwd_clear_ctrl

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import lwd_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic intReset = 1'b0;
  logic vecFetch = 1'b0;
  logic wdTimeout = 1'b0;
  logic [15:0] dataBus = 16'h0000;
  logic [7:0] cfgReg = 8'h00;
  logic prescClr, cntClr, unitCntClr, watchdogDisable, watchdogRateSelect, wdResetReq;
  int nErrors = 0;
  int checksDone = 0;
  integer seed = 56;
  // edges seen with rst low since the latest release
  int relEdges = 0;
  localparam int RunCycles = 9200;
  localparam int MidRstAt = 4600;
  localparam int MidRstLen = 20;
  lwd_clear_ctrl i_dut (.mclk(mclk), .rst(rst), .intReset(intReset), .dataBus(dataBus),
    .vecFetch(vecFetch), .cfgReg(cfgReg), .wdTimeout(wdTimeout), .prescClr(prescClr),
    .cntClr(cntClr), .unitCntClr(unitCntClr), .watchdogDisable(watchdogDisable),
    .watchdogRateSelect(watchdogRateSelect), .wdResetReq(wdResetReq));
  initial forever #20 mclk = ~mclk;
  // ==========================================================
  // checking and closing
  function automatic logic hit(logic vf, logic [15:0] db);
    return vf && (db === LWD_RESET_VECTOR);
  endfunction : hit
  // one pulse on the power-on edge plus every vector hit, nothing while reset is held
  function automatic logic expPresc(logic r, int edges, logic vf, logic [15:0] db);
    return !r && ((edges == LWD_POR_CLR_CYCLES) || hit(vf, db));
  endfunction : expPresc
  task automatic chk(string nm, logic e, logic s);
    checksDone++;
    if (s !== e) begin
      nErrors++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask : chk
  task automatic wrapUp;
    $display("mismatches %0d comparisons %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrapUp
  // the run is RunCycles plus the first reset, so 980 cycles of slack
  initial begin
    #((RunCycles + 1000) * 40);
    nErrors++;
    wrapUp();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(negedge mclk);
    for (int n = 1; n <= RunCycles; n++) begin
      logic [15:0] db;
      logic vf;
      // a second reset mid-run must restart the power-on wait from zero
      rst = (n > MidRstAt) && (n <= MidRstAt + MidRstLen);
      if (rst) begin
        relEdges = 0;
      end else begin
        relEdges++;
      end
      // no random fetches while the power-on count runs, so after the first release its pulse is seen alone
      vf = (relEdges > LWD_POR_CLR_CYCLES + 4) && 1'($random(seed));
      db = 16'($random(seed));
      if (n % 3 == 0) begin
        db = LWD_RESET_VECTOR;
      end
      if (n % 7 == 0) begin
        db = 16'hFFFF;
      end
      // corner: after the second release a fetch lands on the power-on edge itself
      if ((n > MidRstAt) && (relEdges == LWD_POR_CLR_CYCLES)) begin
        vf = 1'b1;
        db = LWD_RESET_VECTOR;
      end
      intReset = 1'($random(seed));
      wdTimeout = 1'($random(seed));
      cfgReg = 8'($random(seed));
      vecFetch = vf;
      dataBus = db;
      #1;
      chk("watchdogDisable", cfgReg[LWD_CFG_DIS_BIT], watchdogDisable);
      chk("watchdogRateSelect", cfgReg[LWD_CFG_RATE_BIT], watchdogRateSelect);
      @(negedge mclk);
      chk("prescClr", expPresc(rst, relEdges, vecFetch, dataBus), prescClr);
      chk("cntClr", !rst && intReset, cntClr);
      chk("unitCntClr", !rst && intReset, unitCntClr);
      chk("wdResetReq", !rst && wdTimeout && !cfgReg[LWD_CFG_DIS_BIT], wdResetReq);
    end
    wrapUp();
  end
endmodule : tb_top
